// >>> design/alu_flags_map.svh
// Register offsets, field positions and reset values of the ALU status flag block
`ifndef ALU_FLAGS_MAP_SVH
`define ALU_FLAGS_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define REG_FLAGS 8'h00
`define REG_OPA 8'h04
`define REG_OPB 8'h08
`define REG_CMD 8'h0C
`define REG_RESULT 8'h10
`define REG_MODE 8'h14

// ----------------------------------------------------------------
// Flag register bit positions
// ----------------------------------------------------------------
`define FLAG_N 4
`define FLAG_OV 3
`define FLAG_Z 2
`define FLAG_DC 1
`define FLAG_C 0
`define FLAG_W 5

// ----------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------
`define CMD_OP_HI 3
`define CMD_OP_LO 0
`define CMD_DEST_FLAGS 4
`define CMD_SRC_FLAGS 5
`define CMD_BIT_HI 8
`define CMD_BIT_LO 6
`define CMD_W 9

// ----------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------
`define MODE_EXT_EN 0
`define MODE_SEL_HI 3
`define MODE_SEL_LO 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FLAGS_RESET 5'h00
`define BYTE_RESET 8'h00
`define CMD_RESET 9'h008
`define MODE_SEL_RESET 3'h2

`endif

// >>> design/alu_flags_pkg.sv
// Types shared by the ALU status flag block
package alu_flags_pkg;

  typedef enum logic [3:0] {
    OP_ADD = 4'h0,
    OP_SUB = 4'h1,
    OP_RLC = 4'h2,
    OP_RRC = 4'h3,
    OP_AND = 4'h4,
    OP_IOR = 4'h5,
    OP_XOR = 4'h6,
    OP_CLR = 4'h7,
    OP_MOV = 4'h8,
    OP_BCF = 4'h9,
    OP_BSF = 4'hA,
    OP_SWAP = 4'hB
  } alu_op_e;

  typedef enum logic [2:0] {
    MODE_INHERENT = 3'h0,
    MODE_LITERAL = 3'h1,
    MODE_DIRECT = 3'h2,
    MODE_INDIRECT = 3'h3,
    MODE_INDEXED = 3'h4
  } addr_mode_e;

  // True for operations that update at least one arithmetic flag
  function automatic logic op_touches_flags(input alu_op_e op);
    logic touches;
    touches = 1'b1;
    if (op == OP_MOV || op == OP_BCF || op == OP_BSF || op == OP_SWAP || op > OP_SWAP)
    begin
      touches = 1'b0;
    end
    return touches;
  endfunction : op_touches_flags

endpackage : alu_flags_pkg

// >>> design/flag_calc.sv
// Combinational ALU result and status flag computation
`timescale 1ns/100ps
`include "alu_flags_map.svh"

module flag_calc
(
  input wire alu_flags_pkg::alu_op_e op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [2:0] bit_sel,
  input wire logic [`FLAG_W-1:0] flags_in,
  output logic [7:0] result,
  output logic [`FLAG_W-1:0] flags_out
);
  import alu_flags_pkg::*;

  logic [7:0] b_eff;
  logic cin;
  logic [8:0] sum;
  logic [4:0] low_sum;

  // Subtraction adds the complement plus one, so carries mean no borrow
  always_comb
  begin
    b_eff = (op == OP_SUB) ? ~b : b;
    cin = (op == OP_SUB);
    sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin};
    low_sum = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
  end

  always_comb
  begin
    result = a;
    flags_out = flags_in;
    unique case (op)
      OP_ADD, OP_SUB:
      begin
        result = sum[7:0];
        flags_out[`FLAG_N] = sum[7];
        flags_out[`FLAG_OV] = (a[7] == b_eff[7]) && (sum[7] != a[7]);
        flags_out[`FLAG_Z] = (sum[7:0] == 8'h00);
        flags_out[`FLAG_DC] = low_sum[4];
        flags_out[`FLAG_C] = sum[8];
      end
      OP_RLC:
      begin
        result = {a[6:0], flags_in[`FLAG_C]};
        flags_out[`FLAG_C] = a[7];
        flags_out[`FLAG_DC] = a[3];
        flags_out[`FLAG_N] = a[6];
        flags_out[`FLAG_Z] = ({a[6:0], flags_in[`FLAG_C]} == 8'h00);
      end
      OP_RRC:
      begin
        result = {flags_in[`FLAG_C], a[7:1]};
        flags_out[`FLAG_C] = a[0];
        flags_out[`FLAG_DC] = a[4];
        flags_out[`FLAG_N] = flags_in[`FLAG_C];
        flags_out[`FLAG_Z] = ({flags_in[`FLAG_C], a[7:1]} == 8'h00);
      end
      OP_AND, OP_IOR, OP_XOR:
      begin
        if (op == OP_AND)
        begin
          result = a & b;
        end
        else if (op == OP_IOR)
        begin
          result = a | b;
        end
        else
        begin
          result = a ^ b;
        end
        flags_out[`FLAG_N] = result[7];
        flags_out[`FLAG_Z] = (result == 8'h00);
      end
      OP_CLR:
      begin
        result = 8'h00;
        flags_out[`FLAG_Z] = 1'b1;
      end
      // Moves and bit operations never disturb the flags
      OP_MOV:
      begin
        result = a;
      end
      OP_BCF:
      begin
        result = a & ~(8'h01 << bit_sel);
      end
      OP_BSF:
      begin
        result = a | (8'h01 << bit_sel);
      end
      OP_SWAP:
      begin
        result = {a[3:0], a[7:4]};
      end
      default:
      begin
        result = a;
      end
    endcase
  end

endmodule : flag_calc

// >>> design/alu_status_flags.sv
// ALU status flag register block with a classic Wishbone register slave
// Behaviour
// - Flag register as destination of a flag-changing operation takes the flags, not result.
// - Clearing the flag register sets zero flag only; other flags keep their values.
// - Bit clear, bit set, nibble swap and moves leave flags untouched unless the flag register is destination; then it takes result bits 4:0.
// - In subtraction carry and digit carry are inverted borrows; one means no borrow.
// - Negative flag, bit 4, copies result bit 7.
// - Overflow flag, bit 3, set on signed two's-complement overflow, else cleared.
// - Zero flag, bit 2, set when arithmetic or logic result is zero.
// - Add and subtract put carry out of result bit 3 into digit carry, bit 1.
// - Add and subtract put carry out of result bit 7 into carry, bit 0.
// - Subtraction adds the two's complement of the second operand.
// - Rotate through carry loads digit carry from source bit 3 or 4.
// - Rotate through carry loads carry from the source's top or bottom bit.
// - Flag register is readable and writable, and usable as source or destination.
// - Indexed literal-offset addressing exists only when the extended set is enabled.
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "alu_flags_map.svh"

module alu_status_flags
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [`FLAG_W-1:0] flags,
  output logic [7:0] result,
  output alu_flags_pkg::addr_mode_e addr_mode
);
  import alu_flags_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] opa;
  logic [7:0] next_opa;
  logic [7:0] opb;
  logic [7:0] next_opb;
  logic [`CMD_W-1:0] cmd;
  logic [`CMD_W-1:0] next_cmd;
  logic ext_en;
  logic next_ext_en;
  logic [`FLAG_W-1:0] next_flags;
  logic [7:0] next_result;
  addr_mode_e next_addr_mode;
  logic [31:0] next_dat;
  logic next_ack;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic is_exec;

  // Byte lane 0 alone gates writes; the command register also takes bit 8 from lane 1
  always_comb
  begin
    req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wr = req && wb_we_i && wb_sel_i[0];
    is_exec = wr && (wb_adr_i == `REG_CMD);
  end

  // ----------------------------------------------------------------
  // Operation issue
  // ----------------------------------------------------------------
  alu_op_e calc_op;
  logic src_flags;
  logic dest_flags;
  logic [7:0] calc_a;
  logic [7:0] calc_result;
  logic [`FLAG_W-1:0] calc_flags;

  // Flag register may serve as the first operand
  always_comb
  begin
    calc_op = alu_op_e'(wb_dat_i[`CMD_OP_HI:`CMD_OP_LO]);
    src_flags = wb_dat_i[`CMD_SRC_FLAGS];
    dest_flags = wb_dat_i[`CMD_DEST_FLAGS];
    calc_a = src_flags ? {3'h0, flags} : opa;
  end

  flag_calc u_calc
  (
    .op(calc_op),
    .a(calc_a),
    .b(opb),
    .bit_sel(wb_dat_i[`CMD_BIT_HI:`CMD_BIT_LO]),
    .flags_in(flags),
    .result(calc_result),
    .flags_out(calc_flags)
  );

  // ----------------------------------------------------------------
  // Addressing mode resolution
  // ----------------------------------------------------------------
  function automatic addr_mode_e resolve_mode(input logic [2:0] sel, input logic ext);
    addr_mode_e mode;
    mode = MODE_DIRECT;
    if (sel == MODE_INHERENT || sel == MODE_LITERAL || sel == MODE_INDIRECT)
    begin
      mode = addr_mode_e'(sel);
    end
    else if (sel == MODE_INDEXED && ext)
    begin
      mode = MODE_INDEXED;
    end
    return mode;
  endfunction : resolve_mode

  // ----------------------------------------------------------------
  // Operand and command registers
  // ----------------------------------------------------------------
  always_comb
  begin
    next_opa = opa;
    next_opb = opb;
    next_cmd = cmd;
    if (wr && wb_adr_i == `REG_OPA)
    begin
      next_opa = wb_dat_i[7:0];
    end
    if (wr && wb_adr_i == `REG_OPB)
    begin
      next_opb = wb_dat_i[7:0];
    end
    if (is_exec)
    begin
      next_cmd = wb_dat_i[`CMD_W-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      opa <= `BYTE_RESET;
      opb <= `BYTE_RESET;
      cmd <= `CMD_RESET;
    end
    else
    begin
      opa <= next_opa;
      opb <= next_opb;
      cmd <= next_cmd;
    end
  end

  // ----------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------
  // Indexed falls back to direct while the extended set is off
  always_comb
  begin
    next_ext_en = ext_en;
    next_addr_mode = addr_mode;
    if (wr && wb_adr_i == `REG_MODE)
    begin
      next_ext_en = wb_dat_i[`MODE_EXT_EN];
      next_addr_mode = resolve_mode(wb_dat_i[`MODE_SEL_HI:`MODE_SEL_LO], wb_dat_i[`MODE_EXT_EN]);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_en <= 1'b0;
      addr_mode <= addr_mode_e'(`MODE_SEL_RESET);
    end
    else
    begin
      ext_en <= next_ext_en;
      addr_mode <= next_addr_mode;
    end
  end

  // ----------------------------------------------------------------
  // Flag and result registers
  // ----------------------------------------------------------------
  always_comb
  begin
    next_flags = flags;
    next_result = result;
    if (wr && wb_adr_i == `REG_FLAGS)
    begin
      // Upper three bits are not stored
      next_flags = wb_dat_i[`FLAG_W-1:0];
    end
    if (is_exec)
    begin
      if (dest_flags)
      begin
        if (op_touches_flags(calc_op))
        begin
          // Computed value is dropped; only the flag update lands
          next_flags = calc_flags;
        end
        else
        begin
          // Flag-neutral operations write their value into the flags
          next_flags = calc_result[`FLAG_W-1:0];
        end
      end
      else
      begin
        next_result = calc_result;
        next_flags = calc_flags;
      end
    end
  end

  // Flags are architecturally unknown after power-up; a fixed value keeps simulation clean
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      flags <= `FLAGS_RESET;
      result <= `BYTE_RESET;
    end
    else
    begin
      flags <= next_flags;
      result <= next_result;
    end
  end

  // ----------------------------------------------------------------
  // Read path and acknowledge
  // ----------------------------------------------------------------
  // Unmapped addresses are acknowledged, read zero, and drop writes
  always_comb
  begin
    next_dat = 32'h0000_0000;
    if (req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        `REG_FLAGS:
        begin
          next_dat = {27'h0000000, flags};
        end
        `REG_OPA:
        begin
          next_dat = {24'h000000, opa};
        end
        `REG_OPB:
        begin
          next_dat = {24'h000000, opb};
        end
        `REG_CMD:
        begin
          next_dat = {23'h000000, cmd};
        end
        `REG_RESULT:
        begin
          next_dat = {24'h000000, result};
        end
        `REG_MODE:
        begin
          next_dat = {28'h0000000, addr_mode, ext_en};
        end
        default:
        begin
          next_dat = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_dat_o <= next_dat;
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge
  // ----------------------------------------------------------------
  // A held request is not taken again while ack stands, so each cycle gets one pulse
  always_comb
  begin
    next_ack = req;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= next_ack;
    end
  end

endmodule : alu_status_flags

// >>> tb/alu_flags_properties.sv
// Port assertions for the ALU status flag block
`timescale 1ns/100ps
`include "alu_flags_map.svh"
module alu_flags_properties
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [`FLAG_W-1:0] flags,
  input wire logic [7:0] result,
  input wire alu_flags_pkg::addr_mode_e addr_mode
);
  import alu_flags_pkg::*;
  // ----
  // Request decode
  // ----
  logic take;
  logic wr;
  logic cmd_wr;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = take && wb_we_i && wb_sel_i[0];
  assign cmd_wr = wr && wb_adr_i == 8'h0C;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_on_take: assert property (take |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_data_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_flags_read: assert property (take && !wb_we_i && wb_adr_i == 8'h00 |=> wb_dat_o == {27'h0, $past(flags)})
    else $error("flag read mismatch");
  a_flags_write: assert property (wr && wb_adr_i == 8'h00 |=> flags == $past(wb_dat_i[4:0]))
    else $error("flag write not taken");
  a_move_keeps_flags: assert property (cmd_wr && wb_dat_i[3:0] inside {4'h8, 4'h9, 4'hA, 4'hB} && !wb_dat_i[4]
    |=> $stable(flags))
    else $error("move or bit op changed flags");
  a_clear_zero_only: assert property (cmd_wr && wb_dat_i[3:0] == 4'h7 |=> flags == ($past(flags) | 5'h04))
    else $error("clear touched other flags");
  a_sign_zero_track: assert property (cmd_wr && wb_dat_i[3:0] < 4'h7 && !wb_dat_i[4]
    |=> flags[4] == result[7] && flags[2] == (result == 8'h00))
    else $error("sign or zero flag wrong");
  a_result_kept_dest: assert property (cmd_wr && wb_dat_i[4] && wb_dat_i[3:0] < 4'h8 |=> $stable(result))
    else $error("result changed while flags were the destination");
  a_flags_hold_idle: assert property (!cmd_wr && !(wr && wb_adr_i == 8'h00) |=> $stable(flags))
    else $error("flags changed without write or operation");
  a_no_index_mode: assert property (wr && wb_adr_i == 8'h14 && !wb_dat_i[0] |=> addr_mode != MODE_INDEXED)
    else $error("indexed mode without extension");
endmodule : alu_flags_properties

// >>> tb/testbench.sv
// Self-checking bench for the ALU status flag block
`timescale 1ns/100ps
`include "alu_flags_map.svh"
module testbench;
  import alu_flags_pkg::*;
  logic clk;
  logic rst;
  logic [7:0] adr;
  logic [31:0] wdat;
  logic [3:0] sel;
  logic we;
  logic cyc;
  logic stb;
  logic [31:0] rdat;
  logic ack;
  logic [4:0] flg;
  logic [7:0] res;
  addr_mode_e mode;
  int error_cnt;
  int checked;
  int cycles;
  int i;
  logic [31:0] lfsr;
  logic [31:0] exp_q[$];
  logic [7:0] adr_q[$];
  logic [4:0] mf;
  logic [7:0] mr;
  alu_status_flags dut (.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .flags(flg), .result(res), .addr_mode(mode));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task tally_and_finish;
    $display("checked %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // ----
  // Bus cycles
  // ----
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    adr <= a;
    we <= w;
    wdat <= d;
    sel <= s;
    do
    begin
      @(posedge clk);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    adr_q.push_back(a);
    wb(a, 1'b0, 32'h0, 4'hF);
  endtask : rd
  always @(posedge clk)
    if (ack === 1'b1 && we === 1'b0 && exp_q.size() > 0)
    begin
      checked++;
      if (rdat !== exp_q[0])
      begin
        $display("[ERR] reg %h exp %h got %h", adr_q[0], exp_q[0], rdat);
        error_cnt++;
      end
      if (adr_q[0] == 8'h00 && flg !== exp_q[0][4:0])
      begin
        $display("[ERR] flags port exp %h got %h", exp_q[0][4:0], flg);
        error_cnt++;
      end
      if (adr_q[0] == 8'h10 && res !== exp_q[0][7:0])
      begin
        $display("[ERR] result port exp %h got %h", exp_q[0][7:0], res);
        error_cnt++;
      end
      if (adr_q[0] == 8'h14 && mode !== exp_q[0][3:1])
      begin
        $display("[ERR] mode port exp %h got %h", exp_q[0][3:1], mode);
        error_cnt++;
      end
      exp_q.pop_front();
      adr_q.pop_front();
    end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ----
  // Operation with reference flags
  // ----
  task automatic run(input logic [7:0] a, input logic [7:0] b, input logic [3:0] o, input logic [2:0] bt,
    input logic d, input logic s);
    logic [8:0] t;
    logic [4:0] h;
    logic [4:0] f;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] r;
    wb(8'h04, 1'b1, {24'h0, a}, 4'h1);
    wb(8'h08, 1'b1, {24'h0, b}, 4'h1);
    wb(8'h0C, 1'b1, {23'h0, bt, s, d, o}, 4'h1);
    x = s ? {3'h0, mf} : a;
    y = o[0] ? ~b : b;
    f = mf;
    r = x;
    if (o < 4'h2)
    begin
      t = {1'b0, x} + {1'b0, y} + {8'h00, o[0]};
      h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, o[0]};
      r = t[7:0];
      f[0] = t[8];
      f[1] = h[4];
      f[3] = (x[7] == y[7]) && (r[7] != x[7]);
    end
    else if (o < 4'h4)
    begin
      r = o[0] ? {mf[0], x[7:1]} : {x[6:0], mf[0]};
      f[0] = o[0] ? x[0] : x[7];
      f[1] = o[0] ? x[4] : x[3];
    end
    else if (o < 4'h7)
      r = o == 4'h4 ? x & b : o == 4'h5 ? x | b : x ^ b;
    else if (o == 4'h7)
      r = 8'h00;
    else if (o == 4'h9)
      r = x & ~(8'h01 << bt);
    else if (o == 4'hA)
      r = x | (8'h01 << bt);
    else if (o == 4'hB)
      r = {x[3:0], x[7:4]};
    if (o < 4'h7)
    begin
      f[4] = r[7];
      f[2] = r == 8'h00;
    end
    if (o == 4'h7)
      f[2] = 1'b1;
    if (!d)
      mr = r;
    mf = (d && o > 4'h7) ? r[4:0] : f;
    rd(8'h00, {27'h0, mf});
    rd(8'h10, {24'h0, mr});
  endtask : run
  initial
  begin
    rst = 1'b1;
    adr = 8'h00;
    wdat = 32'h0;
    sel = 4'h0;
    we = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    error_cnt = 0;
    checked = 0;
    cycles = 0;
    lfsr = 32'h0001489B;
    mf = 5'h1F;
    mr = 8'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h14, 32'h4);
    $display("test reset done");
    wb(8'h00, 1'b1, 32'hFFFFFFFF, 4'h1);
    rd(8'h00, 32'h1F);
    wb(8'h00, 1'b1, 32'h0, 4'hE);
    rd(8'h00, 32'h1F);
    wb(8'h10, 1'b1, 32'h55, 4'hF);
    rd(8'h10, 32'h0);
    rd(8'h40, 32'h0);
    $display("test access done");
    run(8'h7F, 8'h01, 4'h0, 3'h0, 1'b0, 1'b0);
    run(8'h00, 8'h01, 4'h1, 3'h0, 1'b0, 1'b0);
    run(8'h10, 8'h00, 4'h7, 3'h0, 1'b1, 1'b0);
    rd(8'h04, 32'h10);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h17);
    for (i = 0; i < 48; i++)
    begin
      mf = 5'(rnd());
      wb(8'h00, 1'b1, {27'h0, mf}, 4'h1);
      run(8'(rnd()), 8'(rnd()), 4'(i % 16), 3'(rnd()), lfsr[9], lfsr[4]);
    end
    $display("test operations done");
    wb(8'h14, 1'b1, 32'h9, 4'h1);
    rd(8'h14, 32'h9);
    wb(8'h14, 1'b1, 32'h8, 4'h1);
    rd(8'h14, 32'h4);
    wb(8'h14, 1'b1, 32'h3, 4'h1);
    rd(8'h14, 32'h3);
    wb(8'h14, 1'b1, 32'h7, 4'h1);
    rd(8'h14, 32'h7);
    wb(8'h14, 1'b1, 32'h1, 4'h1);
    rd(8'h14, 32'h1);
    wb(8'h14, 1'b1, 32'hD, 4'h1);
    rd(8'h14, 32'h5);
    $display("test modes done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h4);
    $display("test reset again done");
    @(posedge clk);
    tally_and_finish();
  end
endmodule : testbench
bind alu_status_flags alu_flags_properties chk (.clk(clk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .flags(flags), .result(result), .addr_mode(addr_mode));
